// ===== vbt_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "vbt_regs.svh"

module vbt_core
  import vbt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       cfg_wr_en,
  input  wire logic       cfg_rd_en,
  input  wire logic [4:0] cfg_index,
  input  wire vbt_word_t  cfg_wdata,
  output vbt_word_t       cfg_rdata,
  output logic            cfg_rd_valid,
  input  wire logic       dma_need,
  input  wire logic       dma_cycle_busy,
  output logic            dma_go,
  input  wire logic       vme_br_in,
  input  wire logic       vme_bg_in,
  output logic            vme_br_out,
  output logic            vme_bbsy_out,
  input  wire logic       ev_done_ok,
  input  wire logic       ev_ctrl_err,
  input  wire logic       irq_ack,
  output logic            irq_req,
  output logic [2:0]      irq_level,
  output logic [7:0]      irq_vector,
  output logic            err_logged,
  input  wire logic [3:0] jumper_id0,
  input  wire logic [2:0] jumper_id1,
  output logic [3:0]      scsi_id0,
  output logic [2:0]      scsi_id1
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  function automatic vbt_us_t hold_us(input logic [2:0] code);
    hold_us = (code == `VBT_HOLD_FOREVER) ? 11'h000 : (`VBT_TENURE_16_US << code);
  endfunction

  function automatic vbt_us_t off_us(input logic [2:0] code);
    off_us = (code == 3'h0) ? 11'h000 : (`VBT_OFF_BASE_US << code);
  endfunction

  function automatic vbt_us_t burst_us(input logic [7:0] cnt);
    if (cnt == 8'h00) begin
      burst_us = 11'h000;
    end else if (cnt <= `VBT_BURST_R2_MAX) begin
      burst_us = `VBT_TENURE_16_US;
    end else if (cnt <= `VBT_BURST_R3_MAX) begin
      burst_us = `VBT_TENURE_32_US;
    end else begin
      burst_us = `VBT_TENURE_64_US;
    end
  endfunction

  // configuration words, stored exactly as written
  vbt_word_t burst_cfg_reg;
  vbt_word_t normal_irq_reg;
  vbt_word_t error_irq_reg;
  vbt_word_t ch0_id_reg;
  vbt_word_t ch1_id_reg;

  wire wr_burst  = cfg_wr_en && (cfg_index == `VBT_IDX_BURST);
  wire wr_normal = cfg_wr_en && (cfg_index == `VBT_IDX_NORMAL_IRQ);
  wire wr_error  = cfg_wr_en && (cfg_index == `VBT_IDX_ERROR_IRQ);
  wire wr_ch0    = cfg_wr_en && (cfg_index == `VBT_IDX_CH0_ID);
  wire wr_ch1    = cfg_wr_en && (cfg_index == `VBT_IDX_CH1_ID);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      burst_cfg_reg  <= `VBT_RST_WORD;
      normal_irq_reg <= `VBT_RST_WORD;
      error_irq_reg  <= `VBT_RST_WORD;
      ch0_id_reg     <= `VBT_RST_WORD;
      ch1_id_reg     <= `VBT_RST_WORD;
    end else begin
      if (wr_burst)  burst_cfg_reg  <= cfg_wdata;
      if (wr_normal) normal_irq_reg <= cfg_wdata;
      if (wr_error)  error_irq_reg  <= cfg_wdata;
      if (wr_ch0)    ch0_id_reg     <= cfg_wdata;
      if (wr_ch1)    ch1_id_reg     <= cfg_wdata;
    end
  end

  wire vbt_word_t rd_sel =
    (cfg_index == `VBT_IDX_BURST)      ? burst_cfg_reg  :
    (cfg_index == `VBT_IDX_NORMAL_IRQ) ? normal_irq_reg :
    (cfg_index == `VBT_IDX_ERROR_IRQ)  ? error_irq_reg  :
    (cfg_index == `VBT_IDX_CH0_ID)     ? ch0_id_reg     :
    (cfg_index == `VBT_IDX_CH1_ID)     ? ch1_id_reg     : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_rdata    <= 16'h0000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en) cfg_rdata <= rd_sel;
    end
  end

  // tenure mode decode
  wire       time_mode  = burst_cfg_reg[`VBT_BURST_MODE_BIT];
  wire [7:0] burst_cnt  = burst_cfg_reg[7:0];
  wire [2:0] hold_code  = burst_cfg_reg[`VBT_HOLD_LSB +: 3];
  wire [2:0] off_code   = burst_cfg_reg[`VBT_OFF_LSB +: 3];
  wire       fair_en    = time_mode && burst_cfg_reg[`VBT_FAIR_BIT];
  wire       yield_req  = !time_mode && (burst_cnt != 8'h00)
                          && (burst_cnt <= `VBT_BURST_R1_MAX);
  wire vbt_us_t on_limit  = time_mode ? hold_us(hold_code) : burst_us(burst_cnt);
  wire vbt_us_t off_limit = time_mode ? off_us(off_code) : 11'h000;

  vbt_state_t state_reg;
  vbt_state_t state_next;
  logic       timer_start;
  vbt_us_t    timer_limit;
  logic       timer_expired;

  vbt_tenure_timer u_timer (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .start    (timer_start),
    .limit_us (timer_limit),
    .expired  (timer_expired)
  );

  // release on no data, on limit, or on another request in the lowest range
  wire release_cond = !dma_need || timer_expired
                      || (yield_req && vme_br_in);
  wire after_release_off = (off_limit != 11'h000);

  always_comb begin
    state_next  = state_reg;
    timer_start = 1'b0;
    timer_limit = on_limit;
    unique case (state_reg)
      VBT_IDLE: begin
        if (dma_need) begin
          if (fair_en && vme_br_in) begin
            state_next = VBT_WAIT_FAIR;
          end else begin
            state_next = VBT_REQUEST;
          end
        end
      end
      VBT_WAIT_FAIR: begin
        if (!vme_br_in) state_next = VBT_REQUEST;
      end
      VBT_REQUEST: begin
        if (vme_bg_in) begin
          state_next  = VBT_OWN;
          timer_start = 1'b1;
        end
      end
      VBT_OWN: begin
        if (release_cond) begin
          if (dma_cycle_busy) begin
            state_next = VBT_DRAIN;
          end else if (after_release_off) begin
            state_next  = VBT_BACKOFF;
            timer_start = 1'b1;
            timer_limit = off_limit;
          end else begin
            state_next = VBT_IDLE;
          end
        end
      end
      VBT_DRAIN: begin
        if (!dma_cycle_busy) begin
          if (after_release_off) begin
            state_next  = VBT_BACKOFF;
            timer_start = 1'b1;
            timer_limit = off_limit;
          end else begin
            state_next = VBT_IDLE;
          end
        end
      end
      VBT_BACKOFF: begin
        if (timer_expired) state_next = VBT_IDLE;
      end
      default: begin
        state_next = VBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg    <= VBT_IDLE;
      vme_br_out   <= 1'b0;
      vme_bbsy_out <= 1'b0;
      dma_go       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      vme_br_out   <= (state_next == VBT_REQUEST);
      vme_bbsy_out <= (state_next == VBT_OWN) || (state_next == VBT_DRAIN);
      // the expiry flag is stale until the grant restarts the timer
      dma_go       <= (state_next == VBT_OWN) && dma_need && !(yield_req && vme_br_in);
    end
  end

  // completion interrupts; a new event wins over an acknowledge
  wire [2:0] err_level = error_irq_reg[`VBT_LVL_LSB +: 3];
  wire       err_irq   = ev_ctrl_err && (err_level != 3'h0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_req    <= 1'b0;
      irq_level  <= 3'h0;
      irq_vector <= 8'h00;
      err_logged <= 1'b0;
    end else begin
      err_logged <= ev_ctrl_err;
      if (err_irq) begin
        irq_req    <= 1'b1;
        irq_level  <= err_level;
        irq_vector <= error_irq_reg[`VBT_VEC_LSB +: 8];
      end else if (ev_done_ok) begin
        irq_req    <= 1'b1;
        irq_level  <= normal_irq_reg[`VBT_LVL_LSB +: 3];
        irq_vector <= normal_irq_reg[`VBT_VEC_LSB +: 8];
      end else if (irq_ack) begin
        irq_req    <= 1'b0;
      end
    end
  end

  // bus id selection
  wire [3:0] id0_sel =
    ch0_id_reg[`VBT_ID_DEFAULT_BIT] ? jumper_id0 :
    ch0_id_reg[`VBT_ID_EXT_BIT]     ? ch0_id_reg[`VBT_ID_EXT_LSB +: 4] :
                                      {1'b0, ch0_id_reg[2:0]};
  wire [2:0] id1_sel =
    ch1_id_reg[`VBT_ID_DEFAULT_BIT] ? jumper_id1 : ch1_id_reg[2:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scsi_id0 <= 4'h0;
      scsi_id1 <= 3'h0;
    end else begin
      scsi_id0 <= id0_sel;
      scsi_id1 <= id1_sel;
    end
  end

  grant_takes_bus_a: assert property (
    (state_reg == VBT_REQUEST) && vme_bg_in |=> vme_bbsy_out && !vme_br_out)
    else $error("grant did not give bus ownership");

  fair_waits_a: assert property (
    ((state_reg == VBT_IDLE) || (state_reg == VBT_WAIT_FAIR)) && fair_en && vme_br_in
    |=> !vme_br_out)
    else $error("fair mode requested while another request was pending");

  fair_resumes_a: assert property (
    (state_reg == VBT_WAIT_FAIR) && !vme_br_in |=> vme_br_out)
    else $error("fair mode did not request after negation");

  grant_go_a: assert property (
    (state_reg == VBT_REQUEST) && vme_bg_in && dma_need && !(yield_req && vme_br_in)
    |=> dma_go)
    else $error("data cycles not enabled at grant");

  unfair_asks_a: assert property (
    (state_reg == VBT_IDLE) && dma_need && !fair_en |=> vme_br_out)
    else $error("request not raised at once");

  yield_low_range_a: assert property (
    (state_reg == VBT_OWN) && yield_req && vme_br_in && !dma_cycle_busy |=> !vme_bbsy_out)
    else $error("lowest range did not yield to another request");

  ignore_request_a: assert property (
    (state_reg == VBT_OWN) && !time_mode && (burst_cnt > `VBT_BURST_R1_MAX)
    && dma_need && !timer_expired |=> vme_bbsy_out)
    else $error("bus dropped on another request outside lowest range");

  drain_cycle_a: assert property (
    (state_reg == VBT_OWN) && release_cond && dma_cycle_busy |=> vme_bbsy_out && !dma_go)
    else $error("bus released during a data cycle");

  backoff_gap_a: assert property (
    (state_reg == VBT_BACKOFF) |-> !vme_br_out && !vme_bbsy_out)
    else $error("bus requested during time off");

  err_silent_a: assert property (
    ev_ctrl_err && (err_level == 3'h0) && !ev_done_ok && !irq_req && !irq_ack
    |=> !irq_req && err_logged)
    else $error("level zero error raised an interrupt or was not logged");

  normal_irq_a: assert property (
    ev_done_ok && !ev_ctrl_err
    |=> irq_req && irq_vector == $past(normal_irq_reg[7:0]))
    else $error("normal completion vector wrong");

  id0_plain_a: assert property (
    !ch0_id_reg[3] && !ch0_id_reg[4] && !wr_ch0 ##1 !wr_ch0
    |=> scsi_id0 == {1'b0, $past(ch0_id_reg[2:0], 2)})
    else $error("channel 0 id not taken from field");

endmodule // vbt_core

`default_nettype wire

// ===== vbt_regs.svh
// Operation
// - bit 15 selects burst count or time mode
// - count zero holds bus until done
// - counts 1-32: 16 us, done, or request
// - counts 33-64: 16 us or done, ignore requests
// - counts 65-128: 32 us or done
// - counts 129-255: 64 us or done
// - hold code sets tenure, 7 means until done
// - off code sets wait before requesting again
// - fair mode waits for request line negation
// - unfair mode requests at once when needed
// - normal completion uses stored vector and level
// - errors use error vector and level
// - error level zero: no interrupt, still logged
// - channel 0 id from jumpers or field
// - extended mode takes channel 0 id from upper byte
// - channel 1 id from card jumpers or field
`ifndef VBT_REGS_SVH
`define VBT_REGS_SVH

// word indexes inside the controller_init_block
`define VBT_IDX_BURST        5'h01
`define VBT_IDX_NORMAL_IRQ   5'h02
`define VBT_IDX_ERROR_IRQ    5'h03
`define VBT_IDX_CH0_ID       5'h04
`define VBT_IDX_CH1_ID       5'h05

`define VBT_RST_WORD         16'h0000

// dma_burst_config fields
`define VBT_BURST_MODE_BIT   15
`define VBT_FAIR_BIT         14
`define VBT_HOLD_LSB         0
`define VBT_OFF_LSB          4
`define VBT_HOLD_FOREVER     3'h7

// burst count range limits
`define VBT_BURST_R1_MAX     8'h20
`define VBT_BURST_R2_MAX     8'h40
`define VBT_BURST_R3_MAX     8'h80

// level/vector word fields
`define VBT_VEC_LSB          0
`define VBT_LVL_LSB          8

// bus id word fields
`define VBT_ID_DEFAULT_BIT   3
`define VBT_ID_EXT_BIT       4
`define VBT_ID_EXT_LSB       8

// timing
`define VBT_CLK_PERIOD_NS    10
`define VBT_US_NS            1000
`define VBT_US_CYCLES        (`VBT_US_NS / `VBT_CLK_PERIOD_NS)
`define VBT_TENURE_16_US     11'h010
`define VBT_TENURE_32_US     11'h020
`define VBT_TENURE_64_US     11'h040
`define VBT_OFF_BASE_US      11'h008

`endif

// ===== vbt_pkg.sv
package vbt_pkg;

  typedef logic [15:0] vbt_word_t;
  typedef logic [10:0] vbt_us_t;

  typedef enum logic [2:0] {
    VBT_IDLE,
    VBT_WAIT_FAIR,
    VBT_REQUEST,
    VBT_OWN,
    VBT_DRAIN,
    VBT_BACKOFF
  } vbt_state_t;

endpackage

// ===== vbt_tenure_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "vbt_regs.svh"

module vbt_tenure_timer
  import vbt_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    srst,
  input  wire logic    start,
  input  wire vbt_us_t limit_us,
  output logic         expired
);

  logic [6:0] div_reg;
  vbt_us_t    us_reg;
  vbt_us_t    limit_reg;
  wire        tick    = (div_reg == 7'(`VBT_US_CYCLES - 1));
  wire        us_full = (us_reg == 11'h7FF);

  // microsecond enable restarts with each tenure so the first tick is a full us
  always_ff @(posedge clk_sys) begin
    if (srst || start) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= tick ? 7'h00 : div_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      us_reg    <= 11'h000;
      limit_reg <= 11'h000;
    end else if (start) begin
      us_reg    <= 11'h000;
      limit_reg <= limit_us;
    end else if (tick && !us_full) begin
      us_reg    <= us_reg + 11'h001;
    end
  end

  // a zero limit never expires
  always_ff @(posedge clk_sys) begin
    if (srst || start) begin
      expired <= 1'b0;
    end else begin
      expired <= (limit_reg != 11'h000) && (us_reg >= limit_reg);
    end
  end

endmodule // vbt_tenure_timer

`default_nettype wire

// ===== vbt_arb_model.sv
`timescale 1ns/10ps
`default_nettype none

module vbt_arb_model (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic other_req,
  input  wire logic slow,
  input  wire logic vme_br_out,
  input  wire logic vme_bbsy_out,
  output logic      vme_br_in,
  output logic      vme_bg_in
);
  logic [3:0] dly_reg;
  logic [3:0] dly_next;
  logic       grant_due;

  // slow grants wait eight cycles on a held request, prompt ones one
  assign dly_next  = (vme_br_out && !vme_bg_in) ? dly_reg + 4'h1 : 4'h0;
  assign grant_due = vme_br_out && (dly_reg == (slow ? 4'h8 : 4'h1));
  // other requesters show on the line as soon as the bench raises them
  assign vme_br_in = other_req;

  always_ff @(negedge clk_sys) begin
    if (srst) begin
      dly_reg   <= 4'h0;
      vme_bg_in <= 1'b0;
    end else begin
      dly_reg   <= dly_next;
      vme_bg_in <= vme_bg_in ? !vme_bbsy_out : grant_due;
    end
  end
endmodule // vbt_arb_model

`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "vbt_regs.svh"

module tb;
  import vbt_pkg::*;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       cfg_wr_en = 1'b0;
  logic       cfg_rd_en = 1'b0;
  logic [4:0] cfg_index = 5'h00;
  vbt_word_t  cfg_wdata = 16'h0000;
  logic       dma_need = 1'b0;
  logic       dma_cycle_busy = 1'b0;
  logic       ev_done_ok = 1'b0;
  logic       ev_ctrl_err = 1'b0;
  logic       irq_ack = 1'b0;
  logic       other_req = 1'b0;
  logic       slow = 1'b0;
  logic [3:0] jumper_id0 = 4'hB;
  logic [2:0] jumper_id1 = 3'h5;
  vbt_word_t  cfg_rdata;
  logic       cfg_rd_valid, dma_go, vme_br_in, vme_bg_in, vme_br_out, vme_bbsy_out;
  logic       irq_req, err_logged;
  logic [2:0] irq_level, scsi_id1;
  logic [7:0] irq_vector;
  logic [3:0] scsi_id0;
  int         errors = 0;
  int         checks = 0;
  int         n;

  always #5 clk_sys = ~clk_sys;

  vbt_core DUT (.clk_sys, .srst, .cfg_wr_en, .cfg_rd_en, .cfg_index, .cfg_wdata, .cfg_rdata,
    .cfg_rd_valid, .dma_need, .dma_cycle_busy, .dma_go, .vme_br_in, .vme_bg_in, .vme_br_out,
    .vme_bbsy_out, .ev_done_ok, .ev_ctrl_err, .irq_ack, .irq_req, .irq_level, .irq_vector,
    .err_logged, .jumper_id0, .jumper_id1, .scsi_id0, .scsi_id1);

  vbt_arb_model arb (.clk_sys, .srst, .other_req, .slow, .vme_br_out, .vme_bbsy_out,
    .vme_br_in, .vme_bg_in);

  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // sel 0 watches bus busy, sel 1 our request; n counts the cycles taken
  task automatic wt(input int sel, input int val, input int lim);
    n = 0;
    while (((sel != 0) ? vme_br_out : vme_bbsy_out) !== val[0]) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        errors++;
        $display("MISMATCH wait expected %0d seen timeout", val);
        close_out();
      end
    end
  endtask

  task automatic wr(input logic [4:0] idx, input vbt_word_t d);
    cfg_index = idx;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
    idle(3);
  endtask

  task automatic rd(input logic [4:0] idx, input vbt_word_t exp);
    cfg_index = idx;
    cfg_rd_en = 1'b1;
    @(negedge clk_sys);
    cfg_rd_en = 1'b0;
    chk("rd_valid", 16'(cfg_rd_valid), 16'h0001);
    chk("rdata", cfg_rdata, exp);
    idle(1);
  endtask

  // grant to release must match the tenure limit in microseconds
  task automatic tenure(input string nm, input int us);
    dma_need = 1'b1;
    wt(0, 1, 40);
    chk("go at grant", 16'(dma_go), 16'h0001);
    wt(0, 0, us * 100 + 50);
    dma_need = 1'b0;
    chk(nm, 16'(n >= us * 100 && n <= us * 100 + 6), 16'h0001);
    idle(20);
  endtask

  task automatic t_regs;
    wr(`VBT_IDX_BURST, 16'h8072);
    wr(`VBT_IDX_NORMAL_IRQ, 16'h05A5);
    wr(`VBT_IDX_ERROR_IRQ, 16'h033C);
    wr(`VBT_IDX_CH0_ID, 16'h0006);
    wr(`VBT_IDX_CH1_ID, 16'h0002);
    wr(5'h06, 16'hFFFF);
    rd(`VBT_IDX_BURST, 16'h8072);
    rd(`VBT_IDX_NORMAL_IRQ, 16'h05A5);
    rd(`VBT_IDX_ERROR_IRQ, 16'h033C);
    rd(5'h06, 16'h0000);
    rd(5'h00, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_ids;
    chk("id0 field", 16'(scsi_id0), 16'h0006);
    chk("id1 field", 16'(scsi_id1), 16'h0002);
    wr(`VBT_IDX_CH0_ID, 16'h000E);
    wr(`VBT_IDX_CH1_ID, 16'h0008);
    chk("id0 jumper", 16'(scsi_id0), 16'h000B);
    chk("id1 jumper", 16'(scsi_id1), 16'h0005);
    wr(`VBT_IDX_CH0_ID, 16'h0D17);
    chk("id0 ext", 16'(scsi_id0), 16'h000D);
    $display("test ids done");
  endtask

  task automatic t_irq;
    ev_done_ok = 1'b1;
    @(negedge clk_sys);
    ev_done_ok = 1'b0;
    chk("irq normal", {4'h0, irq_req, irq_level, irq_vector}, 16'h0DA5);
    irq_ack = 1'b1;
    @(negedge clk_sys);
    irq_ack = 1'b0;
    chk("irq ack", 16'(irq_req), 16'h0000);
    ev_ctrl_err = 1'b1;
    @(negedge clk_sys);
    ev_ctrl_err = 1'b0;
    chk("irq error", {3'h0, err_logged, irq_req, irq_level, irq_vector}, 16'h1B3C);
    irq_ack = 1'b1;
    @(negedge clk_sys);
    irq_ack = 1'b0;
    wr(`VBT_IDX_ERROR_IRQ, 16'h003C);
    ev_ctrl_err = 1'b1;
    @(negedge clk_sys);
    ev_ctrl_err = 1'b0;
    chk("err level 0", 16'({err_logged, irq_req}), 16'h0002);
    rd(`VBT_IDX_NORMAL_IRQ, 16'h05A5);
    $display("test irq done");
  endtask

  task automatic t_count;
    logic [7:0] cnt[7] = '{8'h20, 8'h21, 8'h40, 8'h41, 8'h80, 8'h81, 8'hFF};
    int         lim[7] = '{16, 16, 16, 32, 32, 64, 64};
    for (int i = 0; i < 7; i++) begin
      wr(`VBT_IDX_BURST, {8'h00, cnt[i]});
      tenure("count tenure", lim[i]);
    end
    wr(`VBT_IDX_BURST, 16'h0000);
    dma_need = 1'b1;
    wt(0, 1, 40);
    idle(6600);
    chk("count0 held", 16'(vme_bbsy_out), 16'h0001);
    dma_need = 1'b0;
    @(negedge clk_sys);
    chk("count0 done", 16'({vme_bbsy_out, dma_go}), 16'h0000);
    idle(20);
    $display("test count done");
  endtask

  task automatic t_br;
    wr(`VBT_IDX_BURST, 16'h0010);
    dma_need = 1'b1;
    wt(0, 1, 40);
    idle(50);
    other_req = 1'b1;
    wt(0, 0, 6);
    dma_need = 1'b0;
    other_req = 1'b0;
    idle(20);
    wr(`VBT_IDX_BURST, 16'h0030);
    dma_need = 1'b1;
    wt(0, 1, 40);
    other_req = 1'b1;
    idle(1000);
    chk("br ignored", 16'(vme_bbsy_out), 16'h0001);
    dma_need = 1'b0;
    other_req = 1'b0;
    idle(20);
    $display("test br done");
  endtask

  task automatic t_time;
    wr(`VBT_IDX_BURST, 16'h8000);
    tenure("hold 16", 16);
    wr(`VBT_IDX_BURST, 16'h8001);
    tenure("hold 32", 32);
    wr(`VBT_IDX_BURST, 16'h8010);
    dma_need = 1'b1;
    wt(0, 1, 40);
    wt(0, 0, 1700);
    wt(1, 1, 1700);
    chk("off 16", 16'(n >= 1600 && n <= 1606), 16'h0001);
    dma_need = 1'b0;
    // let the time off of the last tenure run out before the next test
    idle(1700);
    $display("test time done");
  endtask

  task automatic t_fair;
    wr(`VBT_IDX_BURST, 16'hC007);
    other_req = 1'b1;
    idle(3);
    dma_need = 1'b1;
    idle(20);
    chk("fair waits", 16'(vme_br_out), 16'h0000);
    other_req = 1'b0;
    wt(1, 1, 6);
    wt(0, 1, 40);
    idle(2000);
    chk("hold done", 16'(vme_bbsy_out), 16'h0001);
    dma_need = 1'b0;
    idle(20);
    wr(`VBT_IDX_BURST, 16'h8007);
    other_req = 1'b1;
    idle(3);
    dma_need = 1'b1;
    @(negedge clk_sys);
    chk("unfair", 16'(vme_br_out), 16'h0001);
    dma_need = 1'b0;
    other_req = 1'b0;
    idle(30);
    $display("test fair done");
  endtask

  task automatic t_drain;
    slow = 1'b1;
    wr(`VBT_IDX_BURST, 16'h0000);
    dma_need = 1'b1;
    wt(0, 1, 60);
    dma_cycle_busy = 1'b1;
    dma_need = 1'b0;
    idle(5);
    chk("drain", 16'({vme_bbsy_out, dma_go}), 16'h0002);
    dma_cycle_busy = 1'b0;
    wt(0, 0, 4);
    slow = 1'b0;
    idle(10);
    $display("test drain done");
  endtask

  initial begin
    idle(5);
    srst = 1'b0;
    t_regs();
    t_ids();
    t_irq();
    t_count();
    t_br();
    t_time();
    t_fair();
    t_drain();
    close_out();
  end
endmodule // tb

`default_nettype wire
